// *** hdl/tcau_core.sv ***
// Summary of operation
// - Resolutions 9 to 12 bits supported.
// - Power-up selects 12 bits, sits idle.
// - Command 44h converts, stores valid result, idles.
// - External supply: read slot 0 busy, 1 done.
// - Result stored sixteen bit sign-extended.
// - Low result bits forced to zero below 12 bits.
// - Result resets to 0550h, plus 85 degrees.
// - Trip points are 8-bit two's complement.
// - Trip points at bytes 2, 3, reset to 00h.
// - Compare only result bits 11 to 4.
// - Alarm when at or below low, or at or above high.
// - Alarm re-evaluated after every conversion.
// - Alarm search answered only while flagged.
// - External supply leaves bus free in supply query slot.
// - Supply query read slot low if parasite.
// - Config bits 6 and 5 pick resolution.
// - Bytes 0 and 1 hold result, read-only.
// - Bytes travel least significant bit first.
module tcau_core
   import tcau_pkg::*;
#(
   parameter int CONV_CYCLES_P = CONV_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        clkEn,
   input  wire tcau_cmd_t   cmdIn,
   input  wire tcau_sp_wr_t spWr,
   input  wire logic [3:0]  spRdIndex,
   output logic [7:0]       spRdData,
   input  wire logic        readSlot,
   input  wire logic        supplyParasite,
   input  wire logic        sensorValid,
   input  wire logic [15:0] sensorCode,
   output logic             readBitOut,
   output logic             readBitOe,
   output logic             alarmFlag,
   output logic             alarmSearchActive,
   output logic             convBusy,
   output logic [1:0]       resolution,
   output logic [15:0]      temperatureResult,
   output logic [7:0]       alarmHighTrip,
   output logic [7:0]       alarmLowTrip
);

   localparam int CW = $clog2(CONV_CYCLES_P + 1);

   tcau_state_t   state_q, state_d;
   logic [CW-1:0] count_q, count_d;
   logic [CW-1:0] convLimit;
   logic [15:0]   temp_q, temp_d;
   logic [7:0]    high_q, low_q;
   logic [1:0]    res_q;
   logic          alarm_q, alarm_d;
   logic          lastCmdSupply_q, lastCmdAll_q, lastCmdConv_q;
   logic          supplyQuery_q, readBit_q, readOe_q;

   wire convStart   = cmdIn.valid && cmdIn.code == CMD_CONVERT && state_q == TCAU_IDLE;
   wire convDone    = state_q == TCAU_CONV && count_q == convLimit;
   wire isHighWr    = spWr.wrEn && spWr.index == SP_HIGH_TRIP;
   wire isLowWr     = spWr.wrEn && spWr.index == SP_LOW_TRIP;
   wire isCfgWr     = spWr.wrEn && spWr.index == SP_CONFIG;

   // Conversion time scales by halves per lost bit.
   assign convLimit = CW'(CONV_CYCLES_P >> (RES_DEFAULT - res_q));

   // Undefined low bits are forced to zero at reduced resolution.
   wire [15:0] maskedCode = sensorCode & (16'hFFFF << (RES_DEFAULT - res_q));
   wire [15:0] newTemp    = {{5{maskedCode[10]}}, maskedCode[10:0]};
   wire signed [7:0] cmpTemp = signed'(newTemp[CMP_MSB:CMP_LSB]);
   // Trip points are signed bytes, so the compare must stay signed throughout.
   wire alarmHit = (cmpTemp <= signed'(low_q)) || (cmpTemp >= signed'(high_q));

   always_comb begin
      state_d = state_q;
      count_d = count_q;
      temp_d  = temp_q;
      alarm_d = alarm_q;
      case (state_q)
         TCAU_IDLE: begin
            if (convStart) begin
               state_d = TCAU_CONV;
               count_d = '0;
            end
         end
         TCAU_CONV: begin
            count_d = count_q + CW'(1);
            if (convDone) begin
               state_d = TCAU_IDLE;
               if (sensorValid) begin
                  temp_d = newTemp;
               end
               alarm_d = alarmHit;
            end
         end
         default: state_d = TCAU_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= TCAU_IDLE;
         count_q <= '0;
         temp_q  <= TEMP_RESET;
         alarm_q <= 1'b0;
      end else if (clkEn) begin
         state_q <= state_d;
         count_q <= count_d;
         temp_q  <= temp_d;
         alarm_q <= alarm_d;
      end
   end

   // Trip points and resolution; the result bytes ignore writes.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         high_q <= 8'h00;
         low_q  <= 8'h00;
         res_q  <= RES_DEFAULT;
      end else if (clkEn) begin
         if (isHighWr) begin
            high_q <= spWr.data;
         end
         if (isLowWr) begin
            low_q <= spWr.data;
         end
         if (isCfgWr) begin
            res_q <= {spWr.data[RES_HIGH_BIT], spWr.data[RES_LOW_BIT]};
         end
      end
   end

   // Track the command history that steers read-slot answers.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         lastCmdAll_q    <= 1'b0;
         lastCmdSupply_q <= 1'b0;
         lastCmdConv_q   <= 1'b0;
      end else if (clkEn) begin
         if (cmdIn.valid) begin
            // Command bytes arrive already assembled from the serial stream.
            lastCmdAll_q    <= cmdIn.code == CMD_ADDRESS_ALL;
            lastCmdSupply_q <= cmdIn.code == CMD_READ_SUPPLY && lastCmdAll_q;
            lastCmdConv_q   <= cmdIn.code == CMD_CONVERT;
         end else if (readSlot) begin
            lastCmdSupply_q <= 1'b0;
         end
      end
   end

   // Read-slot answers: supply type once, else progress of conversion on external supply.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         readBit_q <= 1'b1;
         readOe_q  <= 1'b0;
         supplyQuery_q <= 1'b0;
      end else if (clkEn) begin
         supplyQuery_q <= lastCmdSupply_q;
         if (readSlot && lastCmdSupply_q) begin
            readBit_q <= !supplyParasite;
            readOe_q  <= supplyParasite;
         end else if (readSlot && lastCmdConv_q && !supplyParasite) begin
            readBit_q <= state_q != TCAU_CONV;
            readOe_q  <= state_q == TCAU_CONV;
         end else begin
            readBit_q <= 1'b1;
            readOe_q  <= 1'b0;
         end
      end
   end

   wire [7:0] cfgByte = CFG_FIXED | {1'b0, res_q, 5'h00};

   always_comb begin
      if (spRdIndex == SP_TEMP_LSB) begin
         spRdData = temp_q[7:0];
      end else if (spRdIndex == SP_TEMP_MSB) begin
         spRdData = temp_q[15:8];
      end else if (spRdIndex == SP_HIGH_TRIP) begin
         spRdData = high_q;
      end else if (spRdIndex == SP_LOW_TRIP) begin
         spRdData = low_q;
      end else if (spRdIndex == SP_CONFIG) begin
         spRdData = cfgByte;
      end else begin
         spRdData = 8'h00;
      end
   end

   assign readBitOut        = readBit_q;
   assign readBitOe         = readOe_q;
   assign alarmFlag         = alarm_q;
   assign alarmSearchActive = alarm_q;
   assign convBusy          = state_q == TCAU_CONV;
   assign resolution        = res_q;
   assign temperatureResult = temp_q;
   assign alarmHighTrip     = high_q;
   assign alarmLowTrip      = low_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   conv_starts_busy_a: assert property (clkEn && convStart |=> convBusy)
      else $error("conversion did not start");
   conv_ends_idle_a: assert property (clkEn && convDone |=> !convBusy)
      else $error("conversion did not return to idle");
   alarm_update_a: assert property (clkEn && convDone |=> alarmFlag == $past(alarmHit))
      else $error("alarm flag not refreshed");
   alarm_hold_a: assert property (!convDone |=> $stable(alarmFlag))
      else $error("alarm flag changed outside conversion end");
   progress_bit_a: assert property (clkEn && readSlot && !lastCmdSupply_q && lastCmdConv_q
      && !supplyParasite |=> readBitOut == !$past(convBusy))
      else $error("progress read slot wrong");
   supply_bit_a: assert property (clkEn && readSlot && lastCmdSupply_q
      |=> readBitOe == $past(supplyParasite))
      else $error("supply read slot wrong");
   result_ext_a: assert property (temperatureResult[15:11] == {5{temperatureResult[10]}}
      || temperatureResult == TEMP_RESET)
      else $error("result not sign extended");
   search_flag_a: assert property (alarmSearchActive == alarmFlag)
      else $error("search participation mismatch");

   conv_done_c: cover property (convDone);
   alarm_set_c: cover property (convDone ##1 alarmFlag);
   supply_q_c:  cover property (readSlot && lastCmdSupply_q);
   progress_c:  cover property (readSlot && convBusy && !supplyParasite);
   parasite_c:  cover property (readSlot && lastCmdSupply_q && supplyParasite);

   // Read-slot answers: the device only ever pulls the bus low.
   prog_oe_a: assert property (clkEn && readSlot && !lastCmdSupply_q
      && lastCmdConv_q && !supplyParasite |=> readBitOe == $past(convBusy))
      else $error("progress read slot drive wrong");

   parasite_quiet_a: assert property (clkEn && supplyParasite
      && !(readSlot && lastCmdSupply_q) |=> !readBitOe)
      else $error("parasite device drove a progress slot");

   slot_release_a: assert property (clkEn && !readSlot
      |=> readBitOut && !readBitOe)
      else $error("bus not released outside read slot");

   oe_level_a: assert property (readBitOe
      |-> !readBitOut)
      else $error("driven read slot not low");

   // Result register behaviour.
   result_hold_a: assert property (!(clkEn && convDone)
      |=> $stable(temperatureResult))
      else $error("result changed outside conversion end");

   result_keep_a: assert property (clkEn && convDone && !sensorValid
      |=> $stable(temperatureResult))
      else $error("invalid sensor code was stored");

   result_load_a: assert property (clkEn && convDone && sensorValid
      |=> temperatureResult == $past(newTemp))
      else $error("result not loaded at conversion end");

   result_mask_a: assert property (clkEn && convDone && sensorValid
      && res_q == 2'h0 |=> temperatureResult[2:0] == 3'h0)
      else $error("undefined low result bits not cleared");

   // Scratchpad writes.
   high_write_a: assert property (clkEn && isHighWr
      |=> alarmHighTrip == $past(spWr.data))
      else $error("high trip write lost");

   low_write_a: assert property (clkEn && isLowWr
      |=> alarmLowTrip == $past(spWr.data))
      else $error("low trip write lost");

   res_write_a: assert property (clkEn && isCfgWr
      |=> resolution == $past({spWr.data[RES_HIGH_BIT], spWr.data[RES_LOW_BIT]}))
      else $error("resolution write lost");

   // Clock enable and conversion timing.
   freeze_a: assert property (!clkEn
      |=> $stable(state_q) && $stable(count_q) && $stable(alarm_q) && $stable(res_q))
      else $error("state moved while clock enable low");

   conv_bound_a: assert property (convBusy
      |-> count_q <= convLimit)
      else $error("conversion counter overran its limit");

   no_restart_a: assert property (clkEn && convBusy && !convDone
      |=> convBusy && count_q == $past(count_q) + CW'(1))
      else $error("conversion restarted or stalled");

   conv_clear_a: assert property (clkEn && convStart
      |=> count_q == '0)
      else $error("conversion counter not cleared at start");

   // Alarm decision, both trip directions.
   high_alarm_a: assert property (clkEn && convDone
      && cmpTemp >= signed'(high_q) |=> alarmFlag)
      else $error("high trip alarm missed");

   low_alarm_a: assert property (clkEn && convDone
      && cmpTemp <= signed'(low_q) |=> alarmFlag)
      else $error("low trip alarm missed");

endmodule

// *** hdl/tcau_pkg.sv ***
package tcau_pkg;

   // Command codes seen on the bus, least significant bit first.
   localparam logic [7:0] CMD_CONVERT      = 8'h44;
   localparam logic [7:0] CMD_COPY_NV      = 8'h48;
   localparam logic [7:0] CMD_ALARM_SEARCH = 8'hEC;
   localparam logic [7:0] CMD_ADDRESS_ALL  = 8'hCC;
   localparam logic [7:0] CMD_READ_SUPPLY  = 8'hB4;

   // Scratchpad byte indices.
   localparam logic [3:0] SP_TEMP_LSB  = 4'h0;
   localparam logic [3:0] SP_TEMP_MSB  = 4'h1;
   localparam logic [3:0] SP_HIGH_TRIP = 4'h2;
   localparam logic [3:0] SP_LOW_TRIP  = 4'h3;
   localparam logic [3:0] SP_CONFIG    = 4'h4;

   localparam logic [15:0] TEMP_RESET  = 16'h0550;
   localparam logic [1:0]  RES_DEFAULT = 2'h3;
   localparam int          RES_HIGH_BIT = 6;
   localparam int          RES_LOW_BIT  = 5;
   localparam int          CMP_MSB      = 11;
   localparam int          CMP_LSB      = 4;
   localparam logic [7:0]  CFG_FIXED    = 8'h1F;

   // Full conversion time at 12 bits, in microseconds.
   localparam int CONV_TIME_US  = 750000;
   localparam int CLK_MHZ       = 100;
   localparam int CONV_CYCLES   = CONV_TIME_US * CLK_MHZ;

   typedef enum logic [1:0] {
      TCAU_IDLE = 2'b01,
      TCAU_CONV = 2'b10
   } tcau_state_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } tcau_cmd_t;

   typedef struct packed {
      logic       wrEn;
      logic [3:0] index;
      logic [7:0] data;
   } tcau_sp_wr_t;

endpackage

// *** dv/tcau_master.sv ***
module tcau_master
   import tcau_pkg::*;
(
   input  wire logic mclk,
   input  wire logic parasite,
   input  wire logic convBusy,
   output tcau_cmd_t cmdIn,
   output logic      readSlot,
   output logic      strongPullup
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cmdIn = '0;
      readSlot = 1'b0;
   end
   // A parasite-powered device is fed by the pullup for the whole conversion.
   assign strongPullup = parasite & convBusy;
   task automatic send(input logic [7:0] code, input bit last);
      cmdIn <= '{1'b1, code};
      @(posedge mclk);
      if (last) cmdIn <= '0;
   endtask
   task automatic slot();
      if (!strongPullup) readSlot <= 1'b1;
      @(posedge mclk);
      readSlot <= 1'b0;
   endtask
endmodule

// *** dv/temperature_conversion_alarm_unit_tb.sv ***
module temperature_conversion_alarm_unit_tb;
   import tcau_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CONV_P = 64;
   logic        mclk = 1'b0;
   logic        resetn, clkEn, supplyParasite, sensorValid, readSlot;
   logic        readBitOut, readBitOe, alarmFlag, alarmSearchActive, convBusy, strongPullup;
   logic [1:0]  resolution, res;
   logic [3:0]  spRdIndex;
   logic [7:0]  spRdData, alarmHighTrip, alarmLowTrip, hi, lo, t8;
   logic [15:0] sensorCode, temperatureResult, expT;
   logic [31:0] seed = 32'h0000_2a9d;
   logic        expA;
   tcau_cmd_t   cmdIn;
   tcau_sp_wr_t spWr;
   int          n_fail = 0, cmp_count = 0, busyCnt = 0, cyc = 0;

   tcau_core #(.CONV_CYCLES_P(CONV_P)) dut (.mclk(mclk), .resetn(resetn), .clkEn(clkEn),
      .cmdIn(cmdIn), .spWr(spWr), .spRdIndex(spRdIndex), .spRdData(spRdData),
      .readSlot(readSlot), .supplyParasite(supplyParasite), .sensorValid(sensorValid),
      .sensorCode(sensorCode), .readBitOut(readBitOut), .readBitOe(readBitOe),
      .alarmFlag(alarmFlag), .alarmSearchActive(alarmSearchActive), .convBusy(convBusy),
      .resolution(resolution), .temperatureResult(temperatureResult),
      .alarmHighTrip(alarmHighTrip), .alarmLowTrip(alarmLowTrip));
   tcau_master master (.mclk(mclk), .parasite(supplyParasite), .convBusy(convBusy),
      .cmdIn(cmdIn), .readSlot(readSlot), .strongPullup(strongPullup));

   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (convBusy === 1'b1) busyCnt++;
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         test_done();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      spWr <= '{1'b1, i, d};
      @(posedge mclk);
      spWr <= '0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [3:0] i, input logic [7:0] e);
      spRdIndex <= i;
      @(posedge mclk);
      #1;
      chk(spRdData, e);
   endtask
   task automatic test_done();
      $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      resetn = 1'b0;
      clkEn = 1'b1;
      supplyParasite = 1'b0;
      sensorValid = 1'b0;
      sensorCode = '0;
      spWr = '0;
      spRdIndex = '0;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      #1;
      chk(temperatureResult, TEMP_RESET);
      chk(resolution, RES_DEFAULT);
      chk(convBusy, 1'b0);
      rd(SP_CONFIG, {1'b0, RES_DEFAULT, 5'h1F});
      wr(SP_TEMP_LSB, 8'h00);
      rd(SP_TEMP_LSB, 8'h50);
      rd(SP_TEMP_MSB, 8'h05);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         res = (i < 4) ? i[1:0] : seed[9:8];
         expT = {{5{seed[26]}}, seed[26:16]} & (16'hFFFF << (3 - res));
         t8 = expT[11:4];
         hi = (i == 1) ? t8 : ((i == 3) ? 8'h7F : seed[7:0]);
         lo = (i == 2) ? t8 : ((i == 3) ? 8'h80 : seed[15:8]);
         expA = ($signed(t8) <= $signed(lo)) || ($signed(t8) >= $signed(hi));
         sensorCode <= seed[31:16];
         sensorValid <= 1'b1;
         wr(SP_CONFIG, {1'b0, res, 5'h1F});
         wr(SP_HIGH_TRIP, hi);
         wr(SP_LOW_TRIP, lo);
         busyCnt = 0;
         master.send(CMD_CONVERT, 1'b1);
         master.slot();
         #1;
         chk(readBitOut, 1'b0);
         chk(readBitOe, 1'b1);
         for (int n = 0; n < 200 && convBusy; n++) begin
            @(posedge mclk);
            #1;
         end
         chk(busyCnt, (CONV_P >> (3 - res)) + 1);
         chk(temperatureResult, expT);
         chk(alarmFlag, expA);
         chk(alarmSearchActive, expA);
         master.slot();
         #1;
         chk(readBitOut, 1'b1);
         chk(readBitOe, 1'b0);
         rd(SP_TEMP_MSB, expT[15:8]);
         rd(SP_HIGH_TRIP, hi);
         rd(SP_LOW_TRIP, lo);
      end
      $display("test conversions done");
      for (int p = 0; p < 2; p++) begin
         supplyParasite <= p[0];
         @(posedge mclk);
         master.send(CMD_ADDRESS_ALL, 1'b0);
         master.send(CMD_READ_SUPPLY, 1'b1);
         master.slot();
         #1;
         chk(readBitOe, p[0]);
         chk(readBitOut, !p[0]);
      end
      $display("test supply done");
      test_done();
   end
endmodule
